// ### hdl/spi_master_slave_shifter.sv
// master/slave serial shifter with APB register file
//
// Decided for this implementation: the APB register port.
`include "spi_params.svh"
module spi_master_slave_shifter
  import spi_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial clock pin
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  // master out slave in pin
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  // master in slave out pin
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  // slave select input
  input  wire logic        ss_n_in
);
  xfer_state_t state_ff;
  logic [7:0]  ctrl_ff;
  logic        error_irq_enable_ff;
  logic        modfen_ff;
  rate_sel_t   rate_ff;
  logic        rx_full_ff;
  logic        tx_empty_ff;
  logic        ovr_ff;
  logic        mode_fault_flag_ff;
  logic        armed_ff;
  logic        ovr_armed_ff;
  logic        mode_fault_flag_armed_ff;
  logic [7:0]  txbuf_ff;
  logic [7:0]  shreg_ff;
  logic [7:0]  rx_data_ff;
  logic        rx_bit_ff;
  logic [4:0]  cnt_ff;
  logic        sck_ff;
  logic        sck_prev_ff;
  logic        ss_prev_ff;
  logic [31:0] prdata_ff;
  logic [7:0]  nxt_ctrl;

  function automatic logic reg_hit(input logic [9:0] a, input logic [7:0] idx);
    reg_hit = (a == {idx, 2'b00});
  endfunction

  // bus decode
  logic hit_c, hit_s, hit_d, mapped, acc, wr_acc, rd_acc;
  logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
  assign hit_c   = reg_hit(paddr, `IDX_CTRL);
  assign hit_s   = reg_hit(paddr, `IDX_STAT);
  assign hit_d   = reg_hit(paddr, `IDX_DATA);
  assign mapped  = hit_c || hit_s || hit_d;
  assign acc     = psel && penable;
  assign wr_acc  = acc && pwrite && pstrb[0];
  assign rd_acc  = acc && !pwrite;
  assign wr_ctrl = wr_acc && hit_c;
  assign wr_stat = wr_acc && hit_s;
  assign wr_data = wr_acc && hit_d;
  assign rd_stat = rd_acc && hit_s;
  assign rd_data = rd_acc && hit_d;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = prdata_ff;

  logic [7:0] stat_val;
  assign stat_val = {rx_full_ff, error_irq_enable_ff, ovr_ff, mode_fault_flag_ff, tx_empty_ff, modfen_ff, rate_ff};

  // read data is captured in the setup phase so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      if (hit_c) begin
        prdata_ff[7:0] <= ctrl_ff;
      end
      if (hit_s) begin
        prdata_ff[7:0] <= stat_val;
      end
      if (hit_d) begin
        prdata_ff[7:0] <= rx_data_ff;
      end
    end
  end

  // mode and link decode
  logic en, master, clock_polarity_bit, clock_phase_bit, ods, run_m, tick;
  assign en     = ctrl_ff[`CTL_EN];
  assign master = ctrl_ff[`CTL_MSTR];
  assign clock_polarity_bit   = ctrl_ff[`CTL_CLOCK_POLARITY_BIT];
  assign clock_phase_bit   = ctrl_ff[`CTL_CLOCK_PHASE_BIT];
  assign ods    = ctrl_ff[`CTL_ODS];
  assign run_m  = en && master;

  spi_rate_div i_spi_rate_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run_m),
    .rate    (rate_ff),
    .tick    (tick)
  );

  logic mode_fault_flag_evt, ss_fall, slave_on, edge_m, edge_s, edge_evt;
  logic [4:0] edge_num;
  logic leading, sample, last, done, shift_evt, ovr_evt, din, idle, load;
  logic [7:0] rx_word, load_src;

  assign mode_fault_flag_evt = run_m && modfen_ff && !ss_n_in;
  assign ss_fall  = ss_prev_ff && !ss_n_in;
  assign slave_on = en && !master && !ss_n_in;
  assign idle     = (state_ff == ST_IDLE);
  assign edge_m   = run_m && (state_ff == ST_XFER) && tick;
  // the pin is sampled each cycle, so each clock level must last a cycle
  assign edge_s   = slave_on && (sck_in != sck_prev_ff) &&
                    ((state_ff == ST_XFER) || (clock_phase_bit && (sck_prev_ff == clock_polarity_bit)));
  assign edge_evt = master ? edge_m : edge_s;
  assign edge_num = idle ? `FIRST_EDGE : (cnt_ff + 5'h01);
  assign leading  = edge_num[0];
  assign sample   = leading ^ clock_phase_bit;
  assign last     = (edge_num == `LAST_EDGE);
  assign done     = edge_evt && last;
  // phase one: the first edge only starts driving, it must not shift
  assign shift_evt = edge_evt && !sample && !last && (edge_num != `FIRST_EDGE);
  assign din       = master ? miso_in : mosi_in;
  assign rx_word   = {shreg_ff[6:0], (clock_phase_bit ? din : rx_bit_ff)};
  assign ovr_evt   = edge_evt && sample && rx_full_ff &&
                     ((edge_num == `OVR_EDGE_A) || (edge_num == `OVR_EDGE_B));
  assign load      = idle && (wr_data || !tx_empty_ff) && !mode_fault_flag_evt;
  assign load_src  = wr_data ? pwdata[7:0] : txbuf_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else if (!en || mode_fault_flag_evt || (!master && ss_n_in)) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (master && load) begin
            state_ff <= ST_XFER;
          end else if (!master && ((!clock_phase_bit && ss_fall) || edge_evt)) begin
            state_ff <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (done) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 5'h00;
    end else if (edge_evt) begin
      cnt_ff <= edge_num;
    end else if (idle) begin
      cnt_ff <= 5'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg_ff <= 8'h00;
    end else if (load) begin
      shreg_ff <= load_src;
    end else if (done) begin
      shreg_ff <= rx_word;
    end else if (shift_evt) begin
      shreg_ff <= {shreg_ff[6:0], rx_bit_ff};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bit_ff <= 1'b0;
    end else if (edge_evt && sample) begin
      rx_bit_ff <= din;
    end
  end

  // transmit buffer holds a byte written while the shifter is busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txbuf_ff <= 8'h00;
    end else if (wr_data) begin
      txbuf_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_ff <= 1'b1;
    end else if (load || mode_fault_flag_evt) begin
      tx_empty_ff <= 1'b1;
    end else if (wr_data) begin
      tx_empty_ff <= 1'b0;
    end
  end

  // an overrun byte is dropped so the unread one survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_ff <= 8'h00;
    end else if (done && !rx_full_ff) begin
      rx_data_ff <= rx_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full_ff <= 1'b0;
    end else if (done) begin
      rx_full_ff <= 1'b1;
    end else if (armed_ff && rd_data) begin
      rx_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_ff <= 1'b0;
    end else if (rd_stat && rx_full_ff) begin
      armed_ff <= 1'b1;
    end else if (rd_data) begin
      armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_ff       <= 1'b0;
      ovr_armed_ff <= 1'b0;
    end else begin
      if (rd_stat && ovr_ff) begin
        ovr_armed_ff <= 1'b1;
      end else if (rd_data) begin
        ovr_armed_ff <= 1'b0;
      end
      if (ovr_evt) begin
        ovr_ff <= 1'b1;
      end else if (ovr_armed_ff && rd_data) begin
        ovr_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_fault_flag_ff       <= 1'b0;
      mode_fault_flag_armed_ff <= 1'b0;
    end else begin
      if (rd_stat && mode_fault_flag_ff) begin
        mode_fault_flag_armed_ff <= 1'b1;
      end else if (wr_ctrl) begin
        mode_fault_flag_armed_ff <= 1'b0;
      end
      if (mode_fault_flag_evt) begin
        mode_fault_flag_ff <= 1'b1;
      end else if (mode_fault_flag_armed_ff && wr_ctrl) begin
        mode_fault_flag_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = pwdata[7:0] & `CTL_WMASK;
    end
    if (wr_data) begin
      nxt_ctrl[`CTL_TXIE] = 1'b0;
    end
    if (mode_fault_flag_evt) begin
      nxt_ctrl[`CTL_EN] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CTL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_irq_enable_ff  <= 1'b0;
      modfen_ff <= 1'b0;
      rate_ff   <= 2'b00;
    end else if (wr_stat) begin
      error_irq_enable_ff  <= pwdata[`ST_ERROR_IRQ_ENABLE];
      modfen_ff <= pwdata[`ST_MODFEN];
      rate_ff   <= pwdata[`ST_RATE_HI:`ST_RATE_LO];
    end
  end

  // master serial clock rests at the polarity level between bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_ff <= 1'b0;
    end else if (!run_m || (state_ff != ST_XFER)) begin
      sck_ff <= clock_polarity_bit;
    end else if (tick) begin
      sck_ff <= !sck_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_ff <= 1'b0;
      ss_prev_ff  <= 1'b1;
    end else begin
      sck_prev_ff <= sck_in;
      ss_prev_ff  <= ss_n_in;
    end
  end

  // wired-or mode only ever pulls low
  assign sck_out  = sck_ff;
  assign sck_oe   = run_m && !(ods && sck_ff);
  assign mosi_out = shreg_ff[7];
  assign mosi_oe  = run_m && !(ods && shreg_ff[7]);
  assign miso_out = shreg_ff[7];
  assign miso_oe  = slave_on && !(ods && shreg_ff[7]);

  sequence s_mstart;
    master && (state_ff == ST_IDLE) ##1 (state_ff == ST_XFER);
  endsequence

  sequence s_clear;
    armed_ff && rd_data && !done;
  endsequence

  property p_load_at_once;
    @(posedge pclk) disable iff (!presetn)
    wr_data && idle && !mode_fault_flag_evt |=> tx_empty_ff && (shreg_ff == $past(pwdata[7:0]));
  endproperty
  a_load_at_once: assert property (p_load_at_once) else $error("load not at once");

  property p_txie_clear;
    @(posedge pclk) disable iff (!presetn)
    wr_data |=> !ctrl_ff[`CTL_TXIE];
  endproperty
  a_txie_clear: assert property (p_txie_clear) else $error("tx irq enable kept");

  property p_master_start;
    @(posedge pclk) disable iff (!presetn)
    s_mstart |-> $past(run_m) && $past(wr_data || !tx_empty_ff);
  endproperty
  a_master_start: assert property (p_master_start) else $error("bad start");

  property p_rx_copy;
    @(posedge pclk) disable iff (!presetn)
    done && !rx_full_ff |=> rx_full_ff && (rx_data_ff == $past(rx_word));
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("rx byte not copied");

  property p_rx_keep;
    @(posedge pclk) disable iff (!presetn)
    rx_full_ff && !(armed_ff && rd_data) |=> rx_full_ff;
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("rx full lost");

  property p_rx_clear;
    @(posedge pclk) disable iff (!presetn)
    s_clear |=> !rx_full_ff;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx full not cleared");

  property p_ovr_keep;
    @(posedge pclk) disable iff (!presetn)
    done && rx_full_ff |=> $stable(rx_data_ff) && rx_full_ff;
  endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("unread byte overwritten");

  property p_miso_sel;
    @(posedge pclk) disable iff (!presetn)
    miso_oe |-> !ss_n_in && !master && en;
  endproperty
  a_miso_sel: assert property (p_miso_sel) else $error("miso driven unselected");

  property p_sck_own;
    @(posedge pclk) disable iff (!presetn)
    !run_m |-> !sck_oe && !mosi_oe;
  endproperty
  a_sck_own: assert property (p_sck_own) else $error("slave drives clock");

  property p_rate_fast;
    @(posedge pclk) disable iff (!presetn)
    run_m && $past(run_m) && (rate_ff == 2'b00) && ($past(rate_ff) == 2'b00) |-> tick;
  endproperty
  a_rate_fast: assert property (p_rate_fast) else $error("fast rate not bus/2");

  property p_rate_slow;
    @(posedge pclk) disable iff (!presetn)
    tick && run_m && (rate_ff == 2'b11) |=> (!tick) [*8];
  endproperty
  a_rate_slow: assert property (p_rate_slow) else $error("slow rate too fast");

  property p_sck_toggle;
    @(posedge pclk) disable iff (!presetn)
    run_m && (state_ff == ST_XFER) && tick |=> (sck_ff != $past(sck_ff));
  endproperty
  a_sck_toggle: assert property (p_sck_toggle) else $error("clock edge missing");

  property p_mode_fault_flag;
    @(posedge pclk) disable iff (!presetn)
    mode_fault_flag_evt |=> mode_fault_flag_ff && !en && tx_empty_ff && (state_ff == ST_IDLE);
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault not handled");

  property p_slave_start;
    @(posedge pclk) disable iff (!presetn)
    en && !master && !clock_phase_bit && idle && ss_fall |=> (state_ff == ST_XFER);
  endproperty
  a_slave_start: assert property (p_slave_start) else $error("select fall no start");
endmodule

// ### hdl/spi_params.svh
// offsets, field positions, reset values and timing counts of the serial port
`ifndef SPI_PARAMS_SVH
`define SPI_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_CTRL      8'h10
`define IDX_STAT      8'h11
`define IDX_DATA      8'h12

// port_control fields
`define CTL_RXIE      7
`define CTL_MSTR      5
`define CTL_CLOCK_POLARITY_BIT      4
`define CTL_CLOCK_PHASE_BIT      3
`define CTL_ODS       2
`define CTL_EN        1
`define CTL_TXIE      0
`define CTL_WMASK     8'hBF
`define CTL_RST       8'h28

// port_status_and_rate fields
`define ST_RXF        7
`define ST_ERROR_IRQ_ENABLE      6
`define ST_OVR        5
`define ST_MODE_FAULT_FLAG       4
`define ST_TXE        3
`define ST_MODFEN     2
`define ST_RATE_HI    1
`define ST_RATE_LO    0

// half-bit divider terminal counts (bus/2, /8, /32, /128)
`define HALF_R0_M1    7'h00
`define HALF_R1_M1    7'h03
`define HALF_R2_M1    7'h0F
`define HALF_R3_M1    7'h3F

// serial clock edges of one byte
`define FIRST_EDGE    5'h01
`define LAST_EDGE     5'h10
`define OVR_EDGE_A    5'h0D
`define OVR_EDGE_B    5'h0E

`endif

// ### hdl/spi_pkg.sv
// types shared by the serial port design files
package spi_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } xfer_state_t;
  typedef logic [1:0] rate_sel_t;
endpackage

// ### hdl/spi_rate_div.sv
// half-bit enable divider for the master serial clock, held at zero unless run is high
`include "spi_params.svh"
module spi_rate_div
  import spi_pkg::*;
(
  // clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // control
  input  wire logic      run,
  input  wire rate_sel_t rate,
  // half-bit enable pulse
  output logic           tick
);
  logic [6:0] cnt_ff;
  logic [6:0] term;

  always_comb begin
    case (rate)
      2'b00:   term = `HALF_R0_M1;
      2'b01:   term = `HALF_R1_M1;
      2'b10:   term = `HALF_R2_M1;
      default: term = `HALF_R3_M1;
    endcase
  end

  // stopped unless the master is enabled, to save power
  // compare is >= so a rate change mid-count cannot let the counter wrap
  assign tick = run && (cnt_ff >= term);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 7'h00;
    end else if (!run || tick) begin
      cnt_ff <= 7'h00;
    end else begin
      cnt_ff <= cnt_ff + 7'h01;
    end
  end
endmodule

// ### tb/spi_peer_model.sv
// behavioural serial peer that answers as a selected slave device
module spi_peer_model (
  // serial lines
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output logic            miso,
  // format and data
  input  wire logic       clock_polarity_bit,
  input  wire logic       clock_phase_bit,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_ff = 8'h00;
  int         nsam  = 0;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  always @(negedge ss_n) begin
    sh_ff = tx_byte;
    nsam  = 0;
  end
  // sample on the leading edge for phase 0, on the trailing edge for phase 1
  always @(sck) begin
    if (ss_n === 1'b0) begin
      if ((sck !== clock_polarity_bit) ^ clock_phase_bit) begin
        rx_byte = {rx_byte[6:0], mosi};
        nsam++;
      end else if (nsam == 8) begin
        sh_ff = tx_byte;
        nsam  = 0;
      end else if (nsam > 0) begin
        sh_ff = sh_ff << 1;
      end
    end
  end
  // released line shows the inverse so that stale data never passes for a match
  always @(ss_n or sh_ff) begin
    if (ss_n === 1'b0) miso = sh_ff[7];
    else miso = ~miso;
  end
endmodule

// ### tb/spi_master_slave_shifter_tb.sv
// self-checking bench: register access, master traffic to a peer, slave traffic
`include "spi_params.svh"
module spi_master_slave_shifter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] A_CTRL = {`IDX_CTRL, 2'b00};
  localparam logic [9:0] A_STAT = {`IDX_STAT, 2'b00};
  localparam logic [9:0] A_DATA = {`IDX_DATA, 2'b00};
  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [9:0]  paddr     = 10'h000;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        tb_sck    = 1'b0;
  logic        tb_mosi   = 1'b0;
  logic        dut_ss_n  = 1'b1;
  logic        peer_ss_n = 1'b1;
  logic        peer_miso, clock_polarity_bit, clock_phase_bit;
  logic [7:0]  peer_tx   = 8'h00;
  logic [7:0]  peer_rx, txb, rxb;
  wire logic   sck_w     = sck_oe ? sck_out : tb_sck;
  wire logic   mosi_w    = mosi_oe ? mosi_out : tb_mosi;
  wire logic   miso_w    = miso_oe ? miso_out : peer_miso;
  wire logic   mosi_pd;
  // the peer sees mosi through a short wire delay, giving it hold time at its edge
  assign #1 mosi_pd = mosi_w;
  int          miscompares = 0;
  int          comparisons = 0;
  int          nedge       = 0;
  time         t_first, t_last;

  always #4 pclk = ~pclk;

  spi_master_slave_shifter i_spi_master_slave_shifter (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(dut_ss_n));

  spi_peer_model i_spi_peer_model (
    .sck(sck_w), .mosi(mosi_pd), .ss_n(peer_ss_n), .miso(peer_miso), .clock_polarity_bit(clock_polarity_bit),
    .clock_phase_bit(clock_phase_bit), .tx_byte(peer_tx), .rx_byte(peer_rx));

  // edge counter on the driven master clock
  always @(sck_out) begin
    if (sck_oe === 1'b1) begin
      if (nedge == 0) t_first = $time;
      t_last = $time;
      nedge++;
    end
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ends on a falling edge so that later checks see settled outputs
  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ends on pready high; only the watchdog bounds the wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  task automatic wait_edges(input int n);
    for (int k = 0; k < 5000 && nedge < n; k++) @(posedge pclk);
    cyc(4);
  endtask

  // external master for slave mode, each clock level held four bus cycles
  task automatic xmaster(input logic [7:0] tx, output logic [7:0] rx);
    @(posedge pclk);
    dut_ss_n <= 1'b0;
    tb_mosi  <= tx[7];
    cyc(4);
    chk(32'(miso_oe), 32'h1);
    for (int i = 7; i >= 0; i--) begin
      if (!clock_phase_bit) begin
        @(negedge pclk) rx[i] = miso_w;
      end
      @(posedge pclk) tb_sck <= ~clock_polarity_bit;
      if (clock_phase_bit) tb_mosi <= tx[i];
      repeat (3) @(posedge pclk);
      if (clock_phase_bit) begin
        @(negedge pclk) rx[i] = miso_w;
      end
      @(posedge pclk) tb_sck <= clock_polarity_bit;
      if (!clock_phase_bit && i > 0) tb_mosi <= tx[i-1];
      repeat (3) @(posedge pclk);
    end
    @(posedge pclk);
    dut_ss_n <= 1'b1;
    tb_mosi  <= ~tb_mosi;
  endtask

  initial begin
    #200000;
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    logic [31:0] q;
    logic        e;
    {clock_polarity_bit, clock_phase_bit} = 2'b00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(A_CTRL, 32'h28);
    rdc(A_STAT, 32'h08);
    apb(1'b0, 10'h3FC, 32'h0, q, e);
    chk(32'(e), 32'h1);
    for (int m = 0; m < 4; m++) begin
      {clock_polarity_bit, clock_phase_bit} = 2'(m);
      txb = 8'hC6 - 8'(m);
      wr(A_CTRL, 32'h0);
      wr(A_STAT, 32'(m));
      wr(A_CTRL, {26'h0, 1'b1, clock_polarity_bit, clock_phase_bit, 3'b011});
      cyc(3);
      chk(32'(sck_w), 32'(clock_polarity_bit));
      peer_tx = 8'h5A + 8'(m);
      @(posedge pclk) peer_ss_n <= 1'b0;
      nedge = 0;
      wr(A_DATA, 32'(txb));
      rdc(A_CTRL, {26'h0, 1'b1, clock_polarity_bit, clock_phase_bit, 3'b010});
      wait_edges(16);
      chk(32'(nedge), 32'd16);
      chk(32'(t_last - t_first), 32'd120 << (2 * m));
      rdc(A_DATA, 32'(peer_tx));
      rdc(A_STAT, 32'h88 | 32'(m));
      rdc(A_DATA, 32'(peer_tx));
      rdc(A_STAT, 32'h08 | 32'(m));
      chk(32'(peer_rx), 32'(txb));
      @(posedge pclk) peer_ss_n <= 1'b1;
    end
    {clock_polarity_bit, clock_phase_bit} = 2'b01;
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h2A);
    wr(A_STAT, 32'h00);
    peer_tx = 8'h3C;
    @(posedge pclk) peer_ss_n <= 1'b0;
    cyc(1);
    nedge = 0;
    wr(A_DATA, 32'h81);
    wr(A_DATA, 32'h7E);
    rdc(A_STAT, 32'h00);
    wait_edges(32);
    rdc(A_STAT, 32'hA8);
    rdc(A_DATA, 32'h3C);
    chk(32'(peer_rx), 32'h7E);
    rdc(A_STAT, 32'h08);
    wr(A_STAT, 32'h04);
    @(posedge pclk) dut_ss_n <= 1'b0;
    cyc(3);
    chk(32'(sck_oe), 32'h0);
    rdc(A_STAT, 32'h1C);
    rdc(A_CTRL, 32'h28);
    @(posedge pclk) dut_ss_n <= 1'b1;
    peer_ss_n <= 1'b1;
    wr(A_CTRL, 32'h0);
    wr(A_STAT, 32'h0);
    rdc(A_STAT, 32'h08);
    // wired-or master with clock idling high must release the clock pin
    wr(A_CTRL, 32'h36);
    cyc(3);
    chk(32'(sck_oe), 32'h0);
    wr(A_CTRL, 32'h0);
    for (int s = 0; s < 2; s++) begin
      {clock_polarity_bit, clock_phase_bit} = {s[0], s[0]};
      @(posedge pclk) tb_sck <= s[0];
      cyc(2);
      wr(A_CTRL, {27'h0, clock_polarity_bit, clock_phase_bit, 3'b010});
      wr(A_DATA, 32'h96 ^ 32'(s));
      cyc(1);
      chk(32'(miso_oe), 32'h0);
      xmaster(8'h71 + 8'(s), rxb);
      cyc(4);
      chk(32'(miso_oe), 32'h0);
      chk(32'(rxb), 32'h96 ^ 32'(s));
      rdc(A_STAT, 32'h88);
      rdc(A_DATA, 32'h71 + 32'(s));
      wr(A_CTRL, 32'h0);
    end
    tally_and_finish();
  end
endmodule
